// [dmc_debug_mode_control.sv]
/*
 Debug-mode control: decides when instruction fetch is halted for an external
 debug host, holds the debugger control register and drives the debugger reset.
 Assumes a CPU core that reports decoded opcodes, a watchdog taking a refresh
 strobe, and a system reset controller driven from sysResetReq.
*/
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module dmc_debug_mode_control #(
    parameter int RESET_CYCLES = dmc_pkg::DBG_RESET_CYC,
    parameter int BIT_CYC      = dmc_pkg::BIT_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    // Avalon-MM slave
    input  wire logic [3:0] avsAddress,
    input  wire logic       avsRead,
    input  wire logic       avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0] avsByteEnable,
    output logic [31:0]     avsReadData,
    output logic            avsWaitRequest,
    // Reset sources
    input  wire logic       porReset,
    input  wire logic       brownoutReset,
    input  wire logic       sysResetActive,
    // Core and system status
    input  wire logic       opcodeValid,
    input  wire logic [7:0] opcode,
    input  wire logic       haltState,
    input  wire logic       stopState,
    input  wire logic       watchdogEnabled,
    input  wire logic       readProtect,
    // Debug pin
    input  wire logic       debugPinIn,
    output logic            debugPinOut,
    output logic            debugPinOe,
    // Controls to the device
    output logic            fetchStop,
    output logic            breakAsNop,
    output logic            haltRelease,
    output logic            watchdogRefresh,
    output logic            sysClkGate,
    output logic            periphRun,
    output logic            sysResetReq
);
    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Address selects the control register
    function automatic logic hitsControl(input logic [3:0] addr);
        return addr == dmc_pkg::ADDR_CONTROL;
    endfunction : hitsControl

    // Opcode is the breakpoint instruction
    function automatic logic isBreak(input logic [7:0] op);
        return op == dmc_pkg::OPCODE_BREAK;
    endfunction : isBreak

    // Status word seen at the status offset
    function automatic logic [31:0] statusWord(
        input logic halted,
        input logic stopped,
        input logic locked,
        input logic resetting
    );
        logic [31:0] word;
        word                       = 32'h0000_0000;
        word[dmc_pkg::STS_HALT]    = halted;
        word[dmc_pkg::STS_STOP]    = stopped;
        word[dmc_pkg::STS_PROTECT] = locked;
        word[dmc_pkg::STS_RSTBUSY] = resetting;
        return word;
    endfunction : statusWord

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    logic pinMeta;
    logic pinSync;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= 1'b1;
            pinSync <= 1'b1;
        end else if (clkEn) begin
            pinMeta <= debugPinIn;
            pinSync <= pinMeta;
        end
    end

    // ----------------------------------------------------------------
    // Reset tracking and pin sample in last reset cycle
    // ----------------------------------------------------------------
    logic sysResetDly;
    logic pinAtReset;
    logic resetExit;
    assign resetExit = sysResetDly && !sysResetActive;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sysResetDly <= 1'b0;
            pinAtReset  <= 1'b1;
        end else if (clkEn) begin
            sysResetDly <= sysResetActive;
            if (sysResetActive) begin
                pinAtReset <= pinSync;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic [7:0] control;
    logic       debugActive;
    logic       brkEnable;
    logic       ackEnable;
    logic       dbgResetBit;
    logic       accessDone;
    logic       ctlWrite;
    logic       entryBreak;
    logic       entryPin;
    logic       enterDebug;
    logic       hostExit;
    logic       hardExit;
    assign ctlWrite   = avsWrite && !accessDone && avsByteEnable[0]
                        && hitsControl(avsAddress);
    assign entryBreak = opcodeValid && isBreak(opcode) && brkEnable;
    assign entryPin   = resetExit && !pinAtReset;
    assign enterDebug = (entryBreak || entryPin) && !debugActive;
    assign hostExit   = ctlWrite && !avsWriteData[dmc_pkg::BIT_ACTIVE]
                        && !readProtect;
    assign hardExit   = porReset || brownoutReset;

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    logic [$clog2(RESET_CYCLES + 1):0] rstCount;

    // Register image; reserved bits 4:1 read zero
    always_comb begin
        control                      = 8'h00;
        control[dmc_pkg::BIT_ACTIVE] = debugActive;
        control[dmc_pkg::BIT_BREAKPOINT_ENABLE]  = brkEnable;
        control[dmc_pkg::BIT_ACKEN]  = ackEnable;
        control[dmc_pkg::BIT_DBGRST] = dbgResetBit;
    end

    // Breakpoint and acknowledge enables
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            brkEnable <= dmc_pkg::CONTROL_RESET[dmc_pkg::BIT_BREAKPOINT_ENABLE];
            ackEnable <= dmc_pkg::CONTROL_RESET[dmc_pkg::BIT_ACKEN];
        end else if (clkEn) begin
            if (hardExit) begin
                brkEnable <= dmc_pkg::CONTROL_RESET[dmc_pkg::BIT_BREAKPOINT_ENABLE];
                ackEnable <= dmc_pkg::CONTROL_RESET[dmc_pkg::BIT_ACKEN];
            end else if (ctlWrite) begin
                brkEnable <= avsWriteData[dmc_pkg::BIT_BREAKPOINT_ENABLE];
                ackEnable <= avsWriteData[dmc_pkg::BIT_ACKEN];
            end
        end
    end

    // Debug flag: an entry wins over a host clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            debugActive <= dmc_pkg::CONTROL_RESET[dmc_pkg::BIT_ACTIVE];
        end else if (clkEn) begin
            if (hardExit) begin
                debugActive <= dmc_pkg::CONTROL_RESET[dmc_pkg::BIT_ACTIVE];
            end else if (entryBreak || entryPin) begin
                debugActive <= 1'b1;
            end else if (ctlWrite && avsWriteData[dmc_pkg::BIT_ACTIVE]) begin
                debugActive <= 1'b1;
            end else if (hostExit) begin
                debugActive <= 1'b0;
            end
        end
    end

    // Debugger reset bit: set by the host, cleared once its reset is over
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dbgResetBit <= dmc_pkg::CONTROL_RESET[dmc_pkg::BIT_DBGRST];
        end else if (clkEn) begin
            if (hardExit) begin
                dbgResetBit <= dmc_pkg::CONTROL_RESET[dmc_pkg::BIT_DBGRST];
            end else if (ctlWrite && avsWriteData[dmc_pkg::BIT_DBGRST]) begin
                dbgResetBit <= 1'b1;
            end else if (dbgResetBit && rstCount == '0 && !sysResetActive
                         && !sysResetReq && !sysResetDly) begin
                dbgResetBit <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Debugger reset sequencer
    // ----------------------------------------------------------------
    logic rstStart;
    assign rstStart = ctlWrite && avsWriteData[dmc_pkg::BIT_DBGRST]
                      && !control[dmc_pkg::BIT_DBGRST];
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstCount    <= '0;
            sysResetReq <= 1'b0;
        end else if (clkEn) begin
            if (rstStart) begin
                rstCount    <= ($clog2(RESET_CYCLES + 1) + 1)'(RESET_CYCLES);
                sysResetReq <= 1'b1;
            end else if (rstCount != '0) begin
                rstCount    <= rstCount - 1'b1;
                sysResetReq <= (rstCount != 1);
            end else begin
                sysResetReq <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Acknowledge transmitter on the debug pin
    // ----------------------------------------------------------------
    typedef enum {ACK_IDLE, ACK_SEND} dmc_ack_t;
    dmc_ack_t   ackState;
    logic [9:0] ackShift;
    logic [3:0] ackBits;
    logic [$clog2(BIT_CYC + 1):0] ackTimer;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackState    <= ACK_IDLE;
            ackShift    <= '1;
            ackBits     <= 4'h0;
            ackTimer    <= '0;
            debugPinOut <= 1'b1;
            debugPinOe  <= 1'b0;
        end else if (clkEn) begin
            case (ackState)
                ACK_IDLE: begin
                    debugPinOe  <= 1'b0;
                    debugPinOut <= 1'b1;
                    if (enterDebug && control[dmc_pkg::BIT_ACKEN]) begin
                        ackShift <= {1'b1, dmc_pkg::ACK_CHAR, 1'b0};
                        ackBits  <= 4'ha;
                        ackTimer <= '0;
                        ackState <= ACK_SEND;
                    end
                end
                ACK_SEND: begin
                    debugPinOe <= 1'b1;
                    if (ackTimer == '0) begin
                        if (ackBits == 4'h0) begin
                            ackState <= ACK_IDLE;
                        end else begin
                            debugPinOut <= ackShift[0];
                            ackShift    <= {1'b1, ackShift[9:1]};
                            ackBits     <= ackBits - 4'h1;
                            ackTimer    <= ($clog2(BIT_CYC + 1) + 1)'(BIT_CYC - 1);
                        end
                    end else begin
                        ackTimer <= ackTimer - 1'b1;
                    end
                end
                default: ackState <= ACK_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Device controls
    // ----------------------------------------------------------------
    // Fetch stop follows the debug flag; watchdog refresh follows it only while watchdogEnabled is high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetchStop       <= 1'b0;
            watchdogRefresh <= 1'b0;
        end else if (clkEn) begin
            fetchStop       <= debugActive;
            watchdogRefresh <= debugActive && watchdogEnabled;
        end
    end

    // Breakpoint behaviour and halt release on entry
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            breakAsNop  <= 1'b1;
            haltRelease <= 1'b0;
        end else if (clkEn) begin
            breakAsNop  <= !brkEnable;
            haltRelease <= enterDebug && haltState;
        end
    end

    // Clock and peripherals stop only with the stop state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sysClkGate <= 1'b0;
            periphRun  <= 1'b1;
        end else if (clkEn) begin
            sysClkGate <= stopState;
            periphRun  <= !stopState;
        end
    end

    // ----------------------------------------------------------------
    // Bus answer: one wait cycle, then data with waitrequest low
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            accessDone     <= 1'b0;
            avsWaitRequest <= 1'b1;
            avsReadData    <= 32'h0000_0000;
        end else if (clkEn) begin
            if ((avsRead || avsWrite) && !accessDone) begin
                accessDone     <= 1'b1;
                avsWaitRequest <= 1'b0;
                case (avsAddress)
                    dmc_pkg::ADDR_CONTROL: avsReadData <= {24'h000000, control};
                    dmc_pkg::ADDR_STATUS: avsReadData <= statusWord(haltState, stopState,
                                                                    readProtect, sysResetReq);
                    default: avsReadData <= 32'h0000_0000;
                endcase
            end else begin
                accessDone     <= 1'b0;
                avsWaitRequest <= 1'b1;
            end
        end
    end
endmodule : dmc_debug_mode_control
`default_nettype wire

// [dmc_debug_mode_control_sva.sv]
/*
 Checker bound to the debug-mode control block.
 Assumes clkEn stays high while it is watched.
*/
`timescale 1ns/1ns
`default_nettype none
module dmc_debug_mode_control_sva #(
    parameter int RESET_CYCLES = 20
) (
    // Clock, reset and bus
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    input  wire logic       avsRead,
    input  wire logic       avsWrite,
    input  wire logic       avsWaitRequest,
    // Core side
    input  wire logic       opcodeValid,
    input  wire logic [7:0] opcode,
    input  wire logic       haltState,
    input  wire logic       stopState,
    input  wire logic       watchdogEnabled,
    // Controls watched
    input  wire logic       debugPinOut,
    input  wire logic       debugPinOe,
    input  wire logic       fetchStop,
    input  wire logic       breakAsNop,
    input  wire logic       haltRelease,
    input  wire logic       watchdogRefresh,
    input  wire logic       sysClkGate,
    input  wire logic       periphRun,
    input  wire logic       sysResetReq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    int reqCnt;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reqCnt <= 0;
        end else begin
            reqCnt <= sysResetReq ? reqCnt + 1 : 0;
        end
    end
    sequence brkTaken;
        opcodeValid && opcode == 8'h00 && !breakAsNop;
    endsequence
    sequence entered;
        ##[1:3] fetchStop;
    endsequence
    a_wait_answer:
        assert property ($rose(avsRead || avsWrite) && clkEn |=> !avsWaitRequest)
        else $error("bus answer late");
    a_brk_entry:
        assert property (brkTaken |-> entered) else $error("breakpoint missed");
    a_wdog_refresh:
        assert property (watchdogRefresh == (fetchStop && $past(watchdogEnabled)))
        else $error("watchdog refresh wrong");
    a_clk_gate:
        assert property (sysClkGate == $past(stopState)) else $error("clock gated wrongly");
    a_periph_run:
        assert property (periphRun != sysClkGate) else $error("peripherals stopped");
    a_halt_release:
        assert property ($rose(fetchStop) && haltState |-> haltRelease || $past(haltRelease))
        else $error("halt not released");
    a_reset_length:
        assert property ($fell(sysResetReq) |-> reqCnt == RESET_CYCLES)
        else $error("debugger reset length wrong");
    a_ack_start:
        assert property ($rose(debugPinOe) |-> !debugPinOut) else $error("no start bit");
    a_pin_idle:
        assert property (!debugPinOe |-> debugPinOut) else $error("pin idle low");
endmodule : dmc_debug_mode_control_sva
bind dmc_debug_mode_control dmc_debug_mode_control_sva #(.RESET_CYCLES(RESET_CYCLES)) sva_i (.*);
`default_nettype wire

// [dmc_host_model.sv]
/*
 Debug host model: pulls the debug pin low on request and decodes the
 acknowledge frame. Assumes a pull-up on the pin and BIT_CYC clocks a bit.
*/
`timescale 1ns/1ns
`default_nettype none
module dmc_host_model #(
    parameter int BIT_CYC = 4
) (
    // Clock and pin
    input  wire logic       core_clk,
    input  wire logic       holdLow,
    input  wire logic       pinOut,
    input  wire logic       pinOe,
    output logic            pinLevel,
    // Decoded acknowledge
    output logic [7:0]      ackByte
);
    // ----------------------------------------------------------
    // Pin level: device drive, else host pull-down, else pull-up
    // ----------------------------------------------------------
    assign pinLevel = pinOe ? pinOut : !holdLow;
    initial begin
        ackByte = 8'h00;
        forever begin
            @(negedge core_clk);
            if (pinOe && !pinOut) begin
                repeat (BIT_CYC + BIT_CYC / 2 - 1) @(negedge core_clk);
                for (int i = 0; i < 8; i++) begin
                    ackByte[i] = pinLevel;
                    repeat (BIT_CYC) @(negedge core_clk);
                end
            end
        end
    end
endmodule : dmc_host_model
`default_nettype wire

// [dmc_pkg.sv]
/*
 Package for the debug-mode control block: register offsets, field positions,
 reset values and timing counts. Assumes a 20 MHz core clock.
*/
package dmc_pkg;
    // --------------------------------------------------------------
    // Register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    // --------------------------------------------------------------
    // Control register fields
    // --------------------------------------------------------------
    localparam int         BIT_ACTIVE   = 7;
    localparam int         BIT_BREAKPOINT_ENABLE    = 6;
    localparam int         BIT_ACKEN    = 5;
    localparam int         BIT_DBGRST   = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] WRITE_MASK   = 8'he1;
    // --------------------------------------------------------------
    // Status register fields
    // --------------------------------------------------------------
    localparam int         STS_HALT     = 0;
    localparam int         STS_STOP     = 1;
    localparam int         STS_PROTECT  = 2;
    localparam int         STS_RSTBUSY  = 3;
    // --------------------------------------------------------------
    // Instruction and acknowledge codes
    // --------------------------------------------------------------
    localparam logic [7:0] OPCODE_BREAK = 8'h00;
    localparam logic [7:0] ACK_CHAR     = 8'hff;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int         CLK_HZ       = 20000000;
    localparam int         DBG_RESET_NS = 1000;
    localparam int         DBG_RESET_CYC = (DBG_RESET_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int         BIT_CYCLES   = 16;
endpackage : dmc_pkg

// [testbench.sv]
/*
 Self-checking bench for the debug-mode control block.
 Assumes the host model on the debug pin and a bench reset controller.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic core_clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    logic [3:0] avsAddress = 4'h0;
    logic [31:0] avsWriteData = 32'h0, avsReadData;
    logic avsWaitRequest, porReset = 1'b0, brownoutReset = 1'b0, sysResetActive = 1'b0;
    logic opcodeValid = 1'b0, haltState = 1'b0, stopState = 1'b0;
    logic watchdogEnabled = 1'b0, readProtect = 1'b0, holdLow = 1'b0;
    logic [7:0] opcode = 8'h00, ackByte;
    logic pinLevel, debugPinOut, debugPinOe, fetchStop, breakAsNop, haltRelease;
    logic watchdogRefresh, sysClkGate, periphRun, sysResetReq;
    logic [31:0] expQ[$];
    int errors = 0, check_count = 0, seed = 32'hb87e0f59;
    dmc_debug_mode_control #(.RESET_CYCLES(4), .BIT_CYC(4)) dmc_debug_mode_control_i (
        .core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(4'hf), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .porReset(porReset), .brownoutReset(brownoutReset), .sysResetActive(sysResetActive),
        .opcodeValid(opcodeValid), .opcode(opcode), .haltState(haltState),
        .stopState(stopState), .watchdogEnabled(watchdogEnabled), .readProtect(readProtect),
        .debugPinIn(pinLevel), .debugPinOut(debugPinOut), .debugPinOe(debugPinOe),
        .fetchStop(fetchStop), .breakAsNop(breakAsNop), .haltRelease(haltRelease),
        .watchdogRefresh(watchdogRefresh), .sysClkGate(sysClkGate),
        .periphRun(periphRun), .sysResetReq(sysResetReq));
    dmc_host_model #(.BIT_CYC(4)) dmc_host_model_i (.core_clk(core_clk), .holdLow(holdLow),
        .pinOut(debugPinOut), .pinOe(debugPinOe), .pinLevel(pinLevel), .ackByte(ackByte));
    // ----------------------------------------------------------
    // Clock, reset controller and read monitor
    // ----------------------------------------------------------
    initial forever #25 core_clk = !core_clk;
    always @(posedge core_clk) sysResetActive <= sysResetReq;
    always @(posedge core_clk) if (avsRead && avsWaitRequest === 1'b0) chk(avsReadData, expQ.pop_front());
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic waitv(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v) begin
            @(posedge core_clk);
            n++;
            if (n > 500) begin
                errors++;
                end_of_test();
            end
        end
    endtask : waitv
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        avsAddress <= a;
        avsWriteData <= {24'h0, d};
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge core_clk);
        waitv(avsWaitRequest, 1'b0);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back({24'h0, e});
        bus(1'b0, a, 8'h00);
    endtask : rd
    task automatic breakpoint_instruction(input logic [7:0] op);
        opcode <= op;
        opcodeValid <= 1'b1;
        @(posedge core_clk);
        opcodeValid <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : breakpoint_instruction
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(dmc_pkg::ADDR_CONTROL, dmc_pkg::CONTROL_RESET);
        chk(breakAsNop, 1'b1);
        rd(4'h8, 8'h00);
        bus(1'b1, dmc_pkg::ADDR_CONTROL, 8'h5e);
        rd(dmc_pkg::ADDR_CONTROL, 8'h40);
        haltState <= 1'b1;
        watchdogEnabled <= 1'b1;
        for (int i = 0; i < 4; i++) breakpoint_instruction(8'($random(seed)) | 8'h01);
        chk(fetchStop, 1'b0);
        breakpoint_instruction(dmc_pkg::OPCODE_BREAK);
        chk(fetchStop, 1'b1);
        chk(watchdogRefresh, 1'b1);
        rd(dmc_pkg::ADDR_CONTROL, 8'hc0);
        haltState <= 1'b0;
        bus(1'b1, dmc_pkg::ADDR_CONTROL, 8'h40);
        rd(dmc_pkg::ADDR_CONTROL, 8'h40);
        chk(fetchStop, 1'b0);
        readProtect <= 1'b1;
        bus(1'b1, dmc_pkg::ADDR_CONTROL, 8'hc0);
        bus(1'b1, dmc_pkg::ADDR_CONTROL, 8'h40);
        rd(dmc_pkg::ADDR_CONTROL, 8'hc0);
        readProtect <= 1'b0;
        brownoutReset <= 1'b1;
        @(posedge core_clk);
        brownoutReset <= 1'b0;
        rd(dmc_pkg::ADDR_CONTROL, 8'h00);
        bus(1'b1, dmc_pkg::ADDR_CONTROL, 8'h60);
        breakpoint_instruction(dmc_pkg::OPCODE_BREAK);
        waitv(debugPinOe, 1'b1);
        waitv(debugPinOe, 1'b0);
        chk(ackByte, dmc_pkg::ACK_CHAR);
        porReset <= 1'b1;
        @(posedge core_clk);
        porReset <= 1'b0;
        rd(dmc_pkg::ADDR_CONTROL, 8'h00);
        stopState <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk(sysClkGate, 1'b1);
        chk(periphRun, 1'b0);
        rd(dmc_pkg::ADDR_STATUS, 8'h02);
        stopState <= 1'b0;
        holdLow <= 1'b1;
        bus(1'b1, dmc_pkg::ADDR_CONTROL, 8'h41);
        waitv(sysResetActive, 1'b1);
        waitv(sysResetActive, 1'b0);
        repeat (4) @(posedge core_clk);
        holdLow <= 1'b0;
        rd(dmc_pkg::ADDR_CONTROL, 8'hc0);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
